// *** rtl/etm_dir_counter.sv ***
// per-direction byte and packet accumulator for one stream
`timescale 1ns/100ps
module etm_dir_counter #(
   parameter int KEEP_W = etm_pkg::KEEP_W,
   parameter int CNT_W  = etm_pkg::CNT_W
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   // observed beat
   input  wire logic [KEEP_W-1:0] keep,
   input  wire logic              valid,
   input  wire logic              ready,
   input  wire logic              last,
   // window control
   input  wire logic              clearAcc,
   // running totals
   output logic      [CNT_W-1:0]  byteAcc,
   output logic      [CNT_W-1:0]  pktAcc
);
   logic [CNT_W-1:0] next_byteAcc;
   logic [CNT_W-1:0] next_pktAcc;
   logic [CNT_W-1:0] beatBytes;
   logic             beat;

   // popcount of keep gives the bytes moved this beat
   always_comb begin
      beatBytes = '0;
      for (int i = 0; i < KEEP_W; i++) begin
         beatBytes = beatBytes + CNT_W'(keep[i]);
      end
   end

   assign beat = valid & ready;

   // accumulation; a beat in the clearing cycle starts the new window
   always_comb begin
      next_byteAcc = clearAcc ? etm_pkg::CNT_RESET : byteAcc;
      next_pktAcc  = clearAcc ? etm_pkg::CNT_RESET : pktAcc;
      if (beat) begin
         next_byteAcc = next_byteAcc + beatBytes;
         if (last) begin
            // header allowance removed; wraps if the window total so far is under 14 bytes
            next_byteAcc = next_byteAcc - CNT_W'(etm_pkg::HDR_BYTES);
            next_pktAcc  = next_pktAcc + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         byteAcc <= etm_pkg::CNT_RESET;
         pktAcc  <= etm_pkg::CNT_RESET;
      end else begin
         byteAcc <= next_byteAcc;
         pktAcc  <= next_pktAcc;
      end
   end
endmodule

// *** rtl/etm_if.sv ***
// stream pair and statistics joining monitor and traffic end
`timescale 1ns/100ps
interface etm_if;
   logic [etm_pkg::DATA_W-1:0] txData;
   logic [etm_pkg::KEEP_W-1:0] txKeep;
   logic                       txLast;
   logic                       txValid;
   logic                       txUser;
   logic                       txReady;
   logic [etm_pkg::DATA_W-1:0] rxData;
   logic [etm_pkg::KEEP_W-1:0] rxKeep;
   logic                       rxLast;
   logic                       rxValid;
   logic                       rxUser;
   logic                       rxReady;
   logic [etm_pkg::CNT_W-1:0]  txByteCount;
   logic [etm_pkg::CNT_W-1:0]  txPktCount;
   logic [etm_pkg::CNT_W-1:0]  rxByteCount;
   logic [etm_pkg::CNT_W-1:0]  rxPktCount;
   modport monitor (
      input  txData, txKeep, txLast, txValid, txUser, txReady,
      input  rxData, rxKeep, rxLast, rxValid, rxUser, rxReady,
      output txByteCount, txPktCount, rxByteCount, rxPktCount
   );
   modport traffic (
      output txData, txKeep, txLast, txValid, txUser, rxReady,
      input  txReady, rxData, rxKeep, rxLast, rxValid, rxUser,
      input  txByteCount, txPktCount, rxByteCount, rxPktCount
   );
endinterface

// *** rtl/etm_monitor.sv ***
// passive one-second throughput monitor on the tx and rx streams
//
// Function
// - timer counts cycles to one second
// - add transmit bytes on handshaked beats
// - add receive bytes on handshaked beats
// - subtract 14 header bytes on last
// - count transmit packets on last beat
// - count receive packets on last beat
// - report byte counts at four-byte resolution
// - two-bit tag steps once per interval
// - publish counts when timer expires
// - software samples about once per second
// - software retries on unchanged tag
// - keep full except final beat
// - last only together with valid
// - beat needs valid and ready high
// - receive MAC ignores ready; rx counts here still need rxReady high
// - tx underrun low, rx user good
`timescale 1ns/100ps
module etm_monitor #(
   parameter logic [31:0] ONE_SEC_COUNT = etm_pkg::ONE_SEC_CYCLES,
   parameter int          CNT_W         = etm_pkg::CNT_W,
   parameter int          TAG_W         = etm_pkg::TAG_W
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // observed streams and published statistics
   etm_if.monitor    link,
   // expiry marker for local use
   output logic      windowDone
);
   logic [31:0]      timer;
   logic [31:0]      next_timer;
   logic [TAG_W-1:0] tag;
   logic [TAG_W-1:0] next_tag;
   logic             expire;
   // running totals of the open window
   logic [CNT_W-1:0] txBytes;
   logic [CNT_W-1:0] txPkts;
   logic [CNT_W-1:0] rxBytes;
   logic [CNT_W-1:0] rxPkts;
   // next published words
   logic [CNT_W-1:0] next_txB;
   logic [CNT_W-1:0] next_txP;
   logic [CNT_W-1:0] next_rxB;
   logic [CNT_W-1:0] next_rxP;
   // published words; held a whole window so slow software reads agree
   logic [CNT_W-1:0] txByteOut;
   logic [CNT_W-1:0] txPktOut;
   logic [CNT_W-1:0] rxByteOut;
   logic [CNT_W-1:0] rxPktOut;

   assign expire = (timer == ONE_SEC_COUNT - 32'h1);

   always_comb begin
      next_timer = expire ? '0 : timer + 32'h1;
      next_tag   = expire ? tag + TAG_W'(etm_pkg::TAG_STEP) : tag;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         timer <= '0;
         tag   <= etm_pkg::TAG_RESET;
      end else begin
         timer <= next_timer;
         tag   <= next_tag;
      end
   end

   // transmit direction accumulator
   etm_dir_counter #(.KEEP_W(etm_pkg::KEEP_W), .CNT_W(CNT_W)) txCnt (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .keep     (link.txKeep),
      .valid    (link.txValid),
      .ready    (link.txReady),
      .last     (link.txLast),
      .clearAcc (expire),
      .byteAcc  (txBytes),
      .pktAcc   (txPkts)
   );

   // receive direction accumulator; ready is observed though the mac ignores it
   etm_dir_counter #(.KEEP_W(etm_pkg::KEEP_W), .CNT_W(CNT_W)) rxCnt (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .keep     (link.rxKeep),
      .valid    (link.rxValid),
      .ready    (link.rxReady),
      .last     (link.rxLast),
      .clearAcc (expire),
      .byteAcc  (rxBytes),
      .pktAcc   (rxPkts)
   );

   // publish on expiry, values of the closing window
   always_comb begin
      next_txB = txByteOut;
      next_txP = txPktOut;
      next_rxB = rxByteOut;
      next_rxP = rxPktOut;
      if (expire) begin
         // drop two low bits, tag rides there
         next_txB = {txBytes[CNT_W-1:TAG_W], next_tag};
         next_rxB = {rxBytes[CNT_W-1:TAG_W], next_tag};
         next_txP = {txPkts[CNT_W-1:TAG_W], next_tag};
         next_rxP = {rxPkts[CNT_W-1:TAG_W], next_tag};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         txByteOut  <= etm_pkg::CNT_RESET;
         txPktOut   <= etm_pkg::CNT_RESET;
         rxByteOut  <= etm_pkg::CNT_RESET;
         rxPktOut   <= etm_pkg::CNT_RESET;
         windowDone <= 1'b0;
      end else begin
         txByteOut  <= next_txB;
         txPktOut   <= next_txP;
         rxByteOut  <= next_rxB;
         rxPktOut   <= next_rxP;
         windowDone <= expire;
      end
   end

   assign link.txByteCount = txByteOut;
   assign link.txPktCount  = txPktOut;
   assign link.rxByteCount = rxByteOut;
   assign link.rxPktCount  = rxPktOut;
endmodule

// *** rtl/etm_pkg.sv ***
// shared constants and types for the ethernet throughput monitor
package etm_pkg;
   localparam int          DATA_W          = 64;
   localparam int          KEEP_W          = 8;
   localparam int          CNT_W           = 32;
   localparam int          TAG_W           = 2;
   // cycles of the 156.25 MHz clock in one second
   localparam logic [31:0] ONE_SEC_CYCLES  = 32'h09502f90;
   localparam logic [31:0] HDR_BYTES       = 32'h0000000e;
   localparam logic [7:0]  KEEP_FULL       = 8'hff;
   localparam logic [31:0] CNT_RESET       = 32'h00000000;
   localparam logic [1:0]  TAG_RESET       = 2'h0;
   localparam logic [1:0]  TAG_STEP        = 2'h1;
   // register map of the source end's own control port
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_TX_LEN      = 4'h1;
   localparam logic [3:0]  REG_STATUS      = 4'h2;
   localparam logic [3:0]  REG_TX_BYTES    = 4'h3;
   localparam logic [3:0]  REG_TX_PKTS     = 4'h4;
   localparam logic [3:0]  REG_RX_BYTES    = 4'h5;
   localparam logic [3:0]  REG_RX_PKTS     = 4'h6;
   localparam int          CTRL_TX_EN_BIT  = 0;
   localparam int          CTRL_RX_EN_BIT  = 1;
   localparam logic [15:0] TX_LEN_RESET    = 16'h0040;
   typedef enum logic [1:0] {ETM_IDLE, ETM_SEND} etm_gen_state_t;
endpackage

// *** rtl/etm_traffic.sv ***
// traffic source and sink end: frame generator, rx sink, stats sampler
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
module etm_traffic #(
   parameter int AW = 4
) (
   // clock and reset
   input  wire logic          clk_sys,
   input  wire logic          nrst,
   // software port
   input  wire logic [AW-1:0] regAddr,
   input  wire logic [31:0]   regWdata,
   input  wire logic          regWr,
   input  wire logic          regRd,
   output logic      [31:0]   regRdata,
   // streams and statistics
   etm_if.traffic             link
);
   etm_pkg::etm_gen_state_t state, next_state;
   logic [1:0]  ctrl, next_ctrl;
   logic [15:0] txLen, next_txLen;
   logic [15:0] left, next_left;
   logic [7:0]  seq, next_seq;
   logic [31:0] rdata, next_rdata;
   logic        rxGood, next_rxGood;
   logic        beat;

   // beat only on valid and ready
   assign beat = link.txValid & link.txReady;

   // frame generator: txLen bytes per frame, 8 per beat
   always_comb begin
      next_state = state;
      next_left  = left;
      next_seq   = seq;
      unique case (state)
         etm_pkg::ETM_IDLE: begin
            if (ctrl[etm_pkg::CTRL_TX_EN_BIT] && txLen != 16'h0) begin
               next_state = etm_pkg::ETM_SEND;
               next_left  = txLen;
            end
         end
         etm_pkg::ETM_SEND: begin
            if (beat) begin
               next_seq = seq + 8'h1;
               if (left <= 16'h8) begin
                  next_state = etm_pkg::ETM_IDLE;
               end else begin
                  next_left = left - 16'h8;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state <= etm_pkg::ETM_IDLE;
         left  <= '0;
         seq   <= '0;
      end else begin
         state <= next_state;
         left  <= next_left;
         seq   <= next_seq;
      end
   end

   assign link.txValid = (state == etm_pkg::ETM_SEND);
   assign link.txLast  = link.txValid && (left <= 16'h8);
   // keep full except on final beat
   always_comb begin
      link.txKeep = etm_pkg::KEEP_FULL;
      if (link.txLast) begin
         link.txKeep = etm_pkg::KEEP_FULL >> (4'h8 - 4'(left));
      end
   end
   assign link.txData  = {8{seq}};
   assign link.txUser  = 1'b0;
   assign link.rxReady = ctrl[etm_pkg::CTRL_RX_EN_BIT];

   // remember last good rx frame flag
   assign next_rxGood = (link.rxValid && link.rxLast) ? link.rxUser : rxGood;

   // software registers and one-cycle read data
   always_comb begin
      next_ctrl  = ctrl;
      next_txLen = txLen;
      next_rdata = '0;
      if (regWr && regAddr == AW'(etm_pkg::REG_CTRL)) next_ctrl = regWdata[1:0];
      if (regWr && regAddr == AW'(etm_pkg::REG_TX_LEN)) next_txLen = regWdata[15:0];
      if (regRd) begin
         unique case (regAddr)
            AW'(etm_pkg::REG_CTRL):     next_rdata = {30'h0, ctrl};
            AW'(etm_pkg::REG_TX_LEN):   next_rdata = {16'h0, txLen};
            AW'(etm_pkg::REG_STATUS):   next_rdata = {30'h0, rxGood, link.txValid};
            // software samples; tag in bits 1:0 shows freshness
            AW'(etm_pkg::REG_TX_BYTES): next_rdata = link.txByteCount;
            AW'(etm_pkg::REG_TX_PKTS):  next_rdata = link.txPktCount;
            AW'(etm_pkg::REG_RX_BYTES): next_rdata = link.rxByteCount;
            AW'(etm_pkg::REG_RX_PKTS):  next_rdata = link.rxPktCount;
            default:                    next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl   <= '0;
         txLen  <= etm_pkg::TX_LEN_RESET;
         rdata  <= '0;
         rxGood <= 1'b0;
      end else begin
         ctrl   <= next_ctrl;
         txLen  <= next_txLen;
         rdata  <= next_rdata;
         rxGood <= next_rxGood;
      end
   end

   assign regRdata = rdata;
endmodule

// *** verification/ethernet_throughput_monitor_test.sv ***
// bench: monitor and traffic end joined, mac side and software port driven
`timescale 1ns/100ps
module ethernet_throughput_monitor_test;
   localparam int N = 40;
   logic         clk_sys = 1'b0;
   logic         nrst = 1'b0;
   logic [3:0]   regAddr = 4'h0;
   logic [31:0]  regWdata = 32'h0;
   logic         regWr = 1'b0;
   logic         regRd = 1'b0;
   logic         rdLate = 1'b0;
   logic         rdyRand = 1'b0;
   logic         windowDone;
   logic [31:0]  regRdata;
   logic [31:0]  aB[4];
   logic [31:0]  pub[4];
   logic [31:0]  qq[$];
   logic [31:0]  rq[$];
   logic [127:0] snap;
   logic [127:0] cur;
   logic [1:0]   tg;
   int           tm;
   int           err_count = 0;
   int           cmp_count = 0;
   etm_if link();
   etm_monitor #(.ONE_SEC_COUNT(32'(N))) i_etm_monitor (.clk_sys(clk_sys), .nrst(nrst),
      .link(link.monitor), .windowDone(windowDone));
   etm_traffic i_etm_traffic (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .link(link.traffic));
   etm_checker #(.N(32'(N))) i_etm_checker (.clk_sys(clk_sys), .nrst(nrst),
      .txKeep(link.txKeep), .txLast(link.txLast), .txValid(link.txValid),
      .txReady(link.txReady), .rxKeep(link.rxKeep), .rxLast(link.rxLast),
      .rxValid(link.rxValid), .rxReady(link.rxReady), .windowDone(windowDone),
      .txByteCount(link.txByteCount), .txPktCount(link.txPktCount),
      .rxByteCount(link.rxByteCount), .rxPktCount(link.rxPktCount));
   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;
   // mac stalls at random while traffic runs
   always @(posedge clk_sys) link.txReady <= !rdyRand || $urandom_range(3) != 0;
   always @(posedge clk_sys) rdLate <= regRd;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   // answer noted now, compared in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      rq.push_back(e);
      @(posedge clk_sys);
      regRd <= 1'b0;
   endtask
   // bounded wait for a window phase, settled past the edge
   task automatic wait_phase(input int t);
      for (int n = 0; n < 2 * N && tm != t; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (tm != t) begin
         err_count++;
         finish_test();
      end
   endtask
   // full keep until the last beat, sent whatever ready says
   task automatic rx_frame(input int n);
      int nb;
      nb = (n + 7) / 8;
      for (int i = 0; i < nb; i++) begin
         @(posedge clk_sys);
         link.rxValid <= 1'b1;
         link.rxData <= {$urandom, $urandom};
         link.rxLast <= (i == nb - 1);
         link.rxUser <= (i == nb - 1);
         link.rxKeep <= (i == nb - 1) ? 8'hff >> (8 * nb - n) : 8'hff;
      end
      @(posedge clk_sys);
      link.rxValid <= 1'b0;
      link.rxLast <= 1'b0;
      link.rxData <= ~link.rxData;
      link.rxKeep <= 8'($urandom);
   endtask
   // expected publications from beats seen on the wire; expiry beat opens new window
   always @(posedge clk_sys) begin
      if (!nrst) begin
         tm = 0;
         tg = 2'h0;
         aB = '{4{32'h0}};
         pub = '{4{32'h0}};
         qq.delete();
      end else begin
         tm = (tm == N - 1) ? 0 : tm + 1;
         if (tm == 0) begin
            tg = tg + 2'h1;
            for (int i = 0; i < 4; i++) begin
               pub[i] = {aB[i][31:2], tg};
               qq.push_back(pub[i]);
               aB[i] = 32'h0;
            end
         end
         if (link.txValid && link.txReady) begin
            aB[0] = aB[0] + 32'($countones(link.txKeep)) - (link.txLast ? 32'he : 32'h0);
            aB[1] = aB[1] + 32'(link.txLast);
         end
         if (link.rxValid && link.rxReady) begin
            aB[2] = aB[2] + 32'($countones(link.rxKeep)) - (link.rxLast ? 32'he : 32'h0);
            aB[3] = aB[3] + 32'(link.rxLast);
         end
      end
   end
   // each change of the counts takes the oldest notes; a missing note fails
   always @(negedge clk_sys) begin
      cur = {link.txByteCount, link.txPktCount, link.rxByteCount, link.rxPktCount};
      if (nrst && cur !== snap)
         for (int i = 0; i < 4; i++)
            check("count", cur[127-32*i-:32], qq.size() ? qq.pop_front() : 'x);
      snap = cur;
      // transmit end must keep its stream legal on every settled cycle
      if (nrst && link.txValid)
         check("tx underrun", 32'(link.txUser), 32'h0);
      if (nrst && link.txValid && !link.txLast)
         check("tx keep", 32'(link.txKeep), 32'hff);
      if (nrst && !link.txValid)
         check("tx last", 32'(link.txLast), 32'h0);
      if (rdLate)
         check("read data", regRdata, rq.size() ? rq.pop_front() : 'x);
   end
   initial begin
      void'($urandom(23842));
      link.rxValid = 1'b0;
      link.rxLast = 1'b0;
      link.rxUser = 1'b0;
      link.rxKeep = 8'h0;
      link.rxData = 64'h0;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(etm_pkg::REG_CTRL, 32'h0);
      rd(etm_pkg::REG_TX_LEN, 32'h40);
      wr(4'hf, 32'h3);
      rd(4'hf, 32'h0);
      rd(etm_pkg::REG_CTRL, 32'h0);
      $display("test registers done");
      rdyRand <= 1'b1;
      wr(etm_pkg::REG_CTRL, 32'h1);
      for (int k = 0; k < 8; k++) begin
         wr(etm_pkg::REG_TX_LEN, 32'($urandom_range(1, 120)));
         repeat (25) @(posedge clk_sys);
      end
      $display("test transmit done");
      wr(etm_pkg::REG_CTRL, 32'h3);
      for (int k = 0; k < 10; k++) begin
         if (k == 6)
            wr(etm_pkg::REG_CTRL, 32'h1);
         rx_frame($urandom_range(1, 90));
      end
      $display("test receive done");
      wait_phase(3);
      for (int i = 0; i < 4; i++)
         rd(etm_pkg::REG_TX_BYTES + 4'(i), pub[i]);
      $display("test count reads done");
      wait_phase(15);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("reset", link.txByteCount | link.txPktCount | link.rxByteCount | link.rxPktCount, 32'h0);
      check("reset marker", 32'(windowDone), 32'h0);
      @(posedge clk_sys);
      nrst <= 1'b1;
      rd(etm_pkg::REG_TX_LEN, 32'h40);
      wr(etm_pkg::REG_CTRL, 32'h3);
      for (int k = 0; k < 8; k++)
         rx_frame($urandom_range(1, 60));
      wr(etm_pkg::REG_CTRL, 32'h0);
      wait_phase(10);
      check("notes left", 32'(qq.size()), 32'h0);
      // full-rate ready drains the generator; last rx frame ended good
      rdyRand <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rd(etm_pkg::REG_STATUS, 32'h2);
      repeat (2) @(posedge clk_sys);
      $display("test reset done");
      finish_test();
   end
endmodule

// *** verification/etm_checker_sva.sv ***
// assertions on the monitor's window timing and published counts
`timescale 1ns/100ps
module etm_checker #(
   parameter logic [31:0] N = 32'h10
) (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // observed streams
   input wire logic [7:0]  txKeep,
   input wire logic        txLast,
   input wire logic        txValid,
   input wire logic        txReady,
   input wire logic [7:0]  rxKeep,
   input wire logic        rxLast,
   input wire logic        rxValid,
   input wire logic        rxReady,
   // window marker and published counts
   input wire logic        windowDone,
   input wire logic [31:0] txByteCount,
   input wire logic [31:0] txPktCount,
   input wire logic [31:0] rxByteCount,
   input wire logic [31:0] rxPktCount
);
   logic [31:0] ph, tB, tP, rB, rP, tA, rA;
   logic        seen;
   // byte weight of a handshaked beat, header taken off on the last one
   assign tA = (txValid & txReady) ? 32'($countones(txKeep)) - (txLast ? 32'he : 32'h0) : 32'h0;
   assign rA = (rxValid & rxReady) ? 32'($countones(rxKeep)) - (rxLast ? 32'he : 32'h0) : 32'h0;
   // shadow totals; a beat on the expiry cycle opens the new window
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ph <= 32'h0;
         seen <= 1'b0;
         {tB, tP, rB, rP} <= 128'h0;
      end else if (ph == N - 32'h1) begin
         ph <= 32'h0;
         seen <= 1'b1;
         {tB, rB} <= {tA, rA};
         tP <= 32'(txValid & txReady & txLast);
         rP <= 32'(rxValid & rxReady & rxLast);
      end else begin
         ph <= ph + 32'h1;
         {tB, rB} <= {tB + tA, rB + rA};
         tP <= tP + 32'(txValid & txReady & txLast);
         rP <= rP + 32'(rxValid & rxReady & rxLast);
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // publication moment, hold, tag and totals
   period_match_a: assert property (windowDone == (ph == 32'h0 && seen))
      else $error("window end out of step");
   counts_hold_a: assert property (!windowDone |->
      $stable({txByteCount, txPktCount, rxByteCount, rxPktCount})) else $error("counts moved");
   tag_step_a: assert property (windowDone |->
      txByteCount[1:0] == 2'($past(txByteCount) + 32'h1)) else $error("tag step wrong");
   tag_shared_a: assert property (txPktCount[1:0] == txByteCount[1:0] &&
      rxByteCount[1:0] == txByteCount[1:0] && rxPktCount[1:0] == txByteCount[1:0])
      else $error("tag bits differ");
   tx_bytes_a: assert property (windowDone |-> txByteCount[31:2] == $past(tB) >> 2)
      else $error("tx byte total wrong");
   tx_pkts_a: assert property (windowDone |-> txPktCount[31:2] == $past(tP) >> 2)
      else $error("tx packet total wrong");
   rx_bytes_a: assert property (windowDone |-> rxByteCount[31:2] == $past(rB) >> 2)
      else $error("rx byte total wrong");
   rx_pkts_a: assert property (windowDone |-> rxPktCount[31:2] == $past(rP) >> 2)
      else $error("rx packet total wrong");
endmodule
